// ---- rtl/fau_float_unit.sv ----
// floating add, make-absolute and copy-flags datapath with exception handling
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fau_float_unit (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // register port
  input  wire logic [1:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_we,
  input  wire logic                    reg_re,
  output logic      [15:0]             reg_rdata,
  // instruction issue from the cpu core
  input  wire logic                    instr_valid,
  input  wire logic [15:0]             instr_word,
  input  wire logic [fau_pkg::DW-1:0]  float_source_operand,
  input  wire logic [fau_pkg::DW-1:0]  float_dest_operand,
  // results back to the cpu core
  output logic                         done,
  output logic                         result_we,
  output logic      [fau_pkg::DW-1:0]  result_word,
  output logic                         trap,
  output logic      [3:0]              exception_code_reg,
  output logic                         long_int_mode,
  output logic                         cc_valid,
  output logic                         cpu_c,
  output logic                         cpu_v,
  output logic                         cpu_z,
  output logic                         cpu_n
);
  import fau_pkg::*;

  logic undefined_var_trap_en, underflow_int_en, overflow_int_en;
  logic double_precision_sel, truncate_sel;
  logic carry_flag, ovf_flag, zero_flag, neg_flag;

  // decode
  logic       is_float, is_add, is_div, is_abs, is_copy_flags_op, src_mem, dst_mem;
  logic       src_negz, dst_negz, src_zero, dst_zero;
  logic [1:0] register_slot_field;
  logic [3:0] float_opcode_field;

  assign is_float = instr_word[15:12] == OC_FLOAT;
  assign float_opcode_field = instr_word[11:8];
  assign register_slot_field = instr_word[7:6];     // only slots 0..3 encodable
  assign is_add = is_float && float_opcode_field == FOC_ADD;
  assign is_div = is_float && float_opcode_field == FOC_DIV;
  assign is_abs = is_float && instr_word[11:6] == SOP_ABS;
  assign is_copy_flags_op = is_float && instr_word[11:6] == SOP_COPY_FLAGS_OP && instr_word[5:0] == SOP_COPY_FLAGS_OP;
  assign src_mem = instr_word[5:3] != MODE_AC;
  assign dst_mem = src_mem;
  assign src_zero = float_source_operand[EXP_HI:EXP_LO] == EXP_ZERO;
  assign dst_zero = float_dest_operand[EXP_HI:EXP_LO] == EXP_ZERO;
  // fraction bits do not matter for minus zero
  assign src_negz = float_source_operand[SIGN_BIT] && src_zero;
  assign dst_negz = float_dest_operand[SIGN_BIT] && dst_zero;

  // add datapath, one combinational pass
  logic [DW-1:0]         sum_word;
  logic                  sum_ovf, sum_unf, sum_zero;
  always_comb begin
    logic [MW-1:0]        ma, mb;
    logic [WW-1:0]        wa, wb, al, m;
    logic [WW:0]          s, mr;
    logic [7:0]           ea, eb, diff;
    logic                 sa, sb, sticky, found, rbit;
    logic signed [10:0]   ex;
    int                   lz, lsb;
    ma = '0; mb = '0; wa = '0; wb = '0; al = '0; m = '0; s = '0; mr = '0;
    ea = '0; eb = '0; diff = '0; sa = 1'b0; sb = 1'b0; sticky = 1'b0;
    found = 1'b0; rbit = 1'b0; ex = '0; lz = 0;
    lsb = double_precision_sel ? LSB_DBL : LSB_SGL;
    sum_ovf = 1'b0;
    sum_unf = 1'b0;
    sum_zero = 1'b0;
    sum_word = '0;
    // larger magnitude goes to a so the subtract never goes negative
    if ({float_source_operand[EXP_HI:0]} > {float_dest_operand[EXP_HI:0]}) begin
      {sa, ea} = {float_source_operand[SIGN_BIT], float_source_operand[EXP_HI:EXP_LO]};
      {sb, eb} = {float_dest_operand[SIGN_BIT], float_dest_operand[EXP_HI:EXP_LO]};
      ma = {1'b1, float_source_operand[FRAC_HI:0]};
      mb = {1'b1, float_dest_operand[FRAC_HI:0]};
    end else begin
      {sa, ea} = {float_dest_operand[SIGN_BIT], float_dest_operand[EXP_HI:EXP_LO]};
      {sb, eb} = {float_source_operand[SIGN_BIT], float_source_operand[EXP_HI:EXP_LO]};
      ma = {1'b1, float_dest_operand[FRAC_HI:0]};
      mb = {1'b1, float_source_operand[FRAC_HI:0]};
    end
    if (!double_precision_sel) begin  // single keeps 23 fraction bits
      ma[SGL_DROP-1:0] = '0;
      mb[SGL_DROP-1:0] = '0;
    end
    wa = {ma, {(GW+1){1'b0}}};
    wb = {mb, {(GW+1){1'b0}}};
    diff = ea - eb;
    // bits shifted past the guards fold into a sticky bit
    for (int i = 0; i < WW; i++) begin
      if (i < int'(diff)) sticky = sticky | wb[i];
    end
    al = (diff >= 8'(WW)) ? '0 : (wb >> diff);
    al[0] = al[0] | sticky;
    // close exponents never set sticky, so cancellation is exact
    if (sa == sb) s = {1'b0, wa} + {1'b0, al};
    else s = {1'b0, wa} - {1'b0, al};
    ex = 11'(ea);
    if (s[WW]) begin
      m = s[WW:1] | {{(WW-1){1'b0}}, s[0]};
      ex = ex + 11'sd1;
    end else begin
      for (int i = 0; i < WW; i++) begin
        if (!found && s[WW-1-i]) begin
          found = 1'b1;
          lz = i;
        end
      end
      m = s[WW-1:0] << lz;
      ex = ex - 11'(lz);
    end
    // chop below the lsb, then add one lsb when rounding bit is set and truncate_sel is clear
    rbit = m[lsb-1];
    m = m & ~((WW'(1) << lsb) - WW'(1));
    mr = {1'b0, m} + ((!truncate_sel && rbit) ? ((WW+1)'(1) << lsb) : '0);
    if (mr[WW]) begin
      mr = mr >> 1;
      ex = ex + 11'sd1;
    end
    sum_zero = (s == '0);
    sum_ovf = !sum_zero && ex > EXP_MAX;
    sum_unf = !sum_zero && ex < EXP_MIN;
    // low eight exponent bits wrap by 400 octal on overflow or underflow
    sum_word = {sa, ex[7:0], mr[WW-2:GW+1]};
    if (sum_zero) sum_word = '0;
    // an exact-zero operand makes the other the exact result
    if (src_zero) sum_word = dst_zero ? '0 : float_dest_operand;
    else if (dst_zero) sum_word = float_source_operand;
    if (src_zero || dst_zero) begin
      sum_ovf = 1'b0;
      sum_unf = 1'b0;
    end
  end

  // mode register written by software
  always_ff @(posedge clk) begin
    if (srst) begin
      undefined_var_trap_en <= 1'b0;
      underflow_int_en <= 1'b0;
      overflow_int_en <= 1'b0;
      double_precision_sel <= 1'b0;
      long_int_mode <= 1'b0;
      truncate_sel <= 1'b0;
    end else if (reg_we && reg_addr == REG_MODE) begin
      undefined_var_trap_en <= reg_wdata[B_UV];
      underflow_int_en <= reg_wdata[B_UNF];
      overflow_int_en <= reg_wdata[B_OVF];
      double_precision_sel <= reg_wdata[B_DBL];
      long_int_mode <= reg_wdata[B_LONG];
      truncate_sel <= reg_wdata[B_TRUNC];
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk) begin
    if (srst) reg_rdata <= RD_NONE;
    else if (reg_re && reg_addr == REG_MODE)
      reg_rdata <= 16'({undefined_var_trap_en, underflow_int_en, overflow_int_en, 1'b0,
                        double_precision_sel, long_int_mode, truncate_sel, 5'h00});
    else if (reg_re && reg_addr == REG_STAT)
      reg_rdata <= 16'({exception_code_reg, neg_flag, zero_flag, ovf_flag, carry_flag});
    else reg_rdata <= RD_NONE;
  end

  // execution: one instruction per cycle, answer in the next
  logic       store_ok;
  logic [3:0] sum_exc;
  assign store_ok = !(sum_ovf && !overflow_int_en) && !(sum_unf && !underflow_int_en);
  assign sum_exc = sum_ovf ? EXC_OVF : EXC_UNF;

  always_ff @(posedge clk) begin
    if (srst) begin
      done <= 1'b0;
      result_we <= 1'b0;
      result_word <= '0;
      trap <= 1'b0;
      exception_code_reg <= 4'h0;
      {carry_flag, ovf_flag, zero_flag, neg_flag} <= 4'h0;
    end else begin
      done <= instr_valid;
      result_we <= 1'b0;
      trap <= 1'b0;
      if (instr_valid) begin
        if (is_add && undefined_var_trap_en && src_negz && src_mem) begin
          trap <= 1'b1;  // before execution, nothing stored
          exception_code_reg <= EXC_UNDEF;
        end else if (is_add) begin
          result_we <= 1'b1;
          result_word <= store_ok ? sum_word : '0;
          trap <= (sum_ovf || sum_unf) && store_ok;
          if ((sum_ovf || sum_unf) && store_ok) exception_code_reg <= sum_exc;
          carry_flag <= 1'b0;
          ovf_flag <= sum_ovf;
          zero_flag <= !store_ok || sum_word[EXP_HI:EXP_LO] == EXP_ZERO;
          neg_flag <= store_ok && sum_word[SIGN_BIT];
        end else if (is_div && undefined_var_trap_en && src_negz && src_mem) begin
          trap <= 1'b1;
          exception_code_reg <= EXC_UNDEF;
        end else if (is_div && src_zero) begin
          trap <= 1'b1;  // aborted, accumulator untouched
          exception_code_reg <= EXC_DIVZ;
        end else if (is_abs) begin
          result_we <= 1'b1;
          // sign cleared; zero exponent gives exact zero
          result_word <= dst_zero ? '0 : {1'b0, float_dest_operand[DW-2:0]};
          {carry_flag, ovf_flag, neg_flag} <= 3'h0;
          zero_flag <= dst_zero;
          if (undefined_var_trap_en && dst_negz && dst_mem) begin
            trap <= 1'b1;  // after execution
            exception_code_reg <= EXC_UNDEF;
          end
        end else if (!is_copy_flags_op) begin
          trap <= 1'b1;  // unsupported codes take the bad opcode path
          exception_code_reg <= EXC_OPC;
        end
      end
    end
  end

  // condition codes handed to the cpu on copy
  always_ff @(posedge clk) begin
    if (srst) begin
      cc_valid <= 1'b0;
      {cpu_c, cpu_v, cpu_z, cpu_n} <= 4'h0;
    end else begin
      cc_valid <= instr_valid && is_copy_flags_op;
      if (instr_valid && is_copy_flags_op)
        {cpu_c, cpu_v, cpu_z, cpu_n} <= {carry_flag, ovf_flag, zero_flag, neg_flag};
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_add_issue; instr_valid && is_add; endsequence
  sequence s_abs_issue; instr_valid && is_abs; endsequence

  property p_abs_flags;
    s_abs_issue |=> result_we && !result_word[SIGN_BIT] && !carry_flag && !ovf_flag && !neg_flag;
  endproperty
  a_abs_flags: assert property (p_abs_flags) else $error("abs sign or flags wrong");

  property p_abs_negz;
    s_abs_issue ##0 (undefined_var_trap_en && dst_negz && dst_mem)
      |=> trap && result_word == '0 && zero_flag && exception_code_reg == EXC_UNDEF;
  endproperty
  a_abs_negz: assert property (p_abs_negz) else $error("abs minus zero not trapped");

  property p_add_pretrap;
    s_add_issue ##0 (undefined_var_trap_en && src_negz && src_mem) |=> trap && !result_we;
  endproperty
  a_add_pretrap: assert property (p_add_pretrap) else $error("add stored on minus zero source");

  property p_divz;
    instr_valid && is_div && src_zero && !undefined_var_trap_en
      |=> trap && !result_we && exception_code_reg == EXC_DIVZ;
  endproperty
  a_divz: assert property (p_divz) else $error("divide by zero not trapped");

  property p_copy;
    instr_valid && is_copy_flags_op |=> cc_valid && cpu_c == carry_flag && cpu_v == ovf_flag
      && cpu_z == zero_flag && cpu_n == neg_flag;
  endproperty
  a_copy: assert property (p_copy) else $error("copied flags differ");

  property p_zero_src;
    s_add_issue ##0 (src_zero && !src_negz && !dst_zero) |=> result_word == $past(float_dest_operand);
  endproperty
  a_zero_src: assert property (p_zero_src) else $error("zero source changed result");

  property p_negz_store;
    result_we && result_word[SIGN_BIT] && result_word[EXP_HI:EXP_LO] == EXP_ZERO |-> trap;
  endproperty
  a_negz_store: assert property (p_negz_store) else $error("minus zero stored silently");

  property p_unf_zero;
    s_add_issue ##0 (sum_unf && !underflow_int_en) |=> result_word == '0 && !trap;
  endproperty
  a_unf_zero: assert property (p_unf_zero) else $error("underflow not replaced by zero");

  property p_ovf_flag;
    s_add_issue ##0 (sum_ovf && overflow_int_en) |=> ovf_flag && !carry_flag && trap
      && exception_code_reg == EXC_OVF ##1 (done || !trap);
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag or code wrong");

  property p_done;
    done |-> $past(instr_valid);
  endproperty
  a_done: assert property (p_done) else $error("done without issue");

  // an add that is not stopped by the minus zero trap
  sequence s_add_exec;
    s_add_issue ##0 !(undefined_var_trap_en && src_negz && src_mem);
  endsequence

  // flags must describe the word actually written back
  property p_add_flags;
    s_add_exec |=> result_we && !carry_flag && neg_flag == result_word[SIGN_BIT]
      && zero_flag == (result_word[EXP_HI:EXP_LO] == EXP_ZERO);
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flags differ from stored value");

  // disabled overflow leaves exact zero, flag still raised
  property p_ovf_off;
    s_add_issue ##0 (sum_ovf && !overflow_int_en) |=> result_we && result_word == '0 && !trap && ovf_flag
      && zero_flag;
  endproperty
  a_ovf_off: assert property (p_ovf_off) else $error("disabled overflow not zeroed");

  // enabled underflow keeps the wrapped word and traps
  property p_unf_en;
    s_add_issue ##0 (sum_unf && underflow_int_en) |=> result_we && trap && !ovf_flag
      && exception_code_reg == EXC_UNF;
  endproperty
  a_unf_en: assert property (p_unf_en) else $error("enabled underflow not trapped");

  // single results from two nonzero operands never carry the low fraction word
  property p_single_low;
    s_add_exec ##0 (!double_precision_sel && !src_zero && !dst_zero) |=> result_word[SGL_DROP-1:0] == '0;
  endproperty
  a_single_low: assert property (p_single_low) else $error("single result has low bits");

  // the code changes only together with a trap
  property p_exc_hold;
    !trap |-> $stable(exception_code_reg);
  endproperty
  a_exc_hold: assert property (p_exc_hold) else $error("exception code moved without trap");

  // no pulse without an issue one cycle before
  property p_quiet;
    !instr_valid |=> !done && !result_we && !trap && !cc_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pulse without an issued instruction");
endmodule : fau_float_unit
`default_nettype wire

// ---- rtl/fau_pkg.sv ----
// constants for the floating arithmetic datapath
package fau_pkg;
  localparam int MW = 56;             // mantissa incl. hidden bit
  localparam int GW = 2;              // guard bits
  localparam int WW = MW + GW + 1;    // working width, plus sticky
  localparam int DW = 64;
  localparam int SIGN_BIT = 63;
  localparam int EXP_HI = 62;
  localparam int EXP_LO = 55;
  localparam int FRAC_HI = 54;
  localparam int SGL_DROP = 32;       // fraction bits unused in single
  localparam int LSB_DBL = GW + 1;
  localparam int LSB_SGL = GW + 1 + SGL_DROP;
  localparam logic signed [10:0] EXP_MAX = 11'sh0ff;
  localparam logic signed [10:0] EXP_MIN = 11'sh001;
  localparam logic [7:0] EXP_ZERO = 8'h00;
  // instruction word fields
  localparam logic [3:0] OC_FLOAT = 4'hf;
  localparam logic [3:0] FOC_ADD = 4'h5;
  localparam logic [3:0] FOC_DIV = 4'h9;
  localparam logic [3:0] FOC_SINGLE = 4'h0;
  localparam logic [5:0] SOP_ABS = 6'h06;
  localparam logic [5:0] SOP_COPY_FLAGS_OP = 6'h00;
  localparam logic [2:0] MODE_AC = 3'h0;
  // exception codes
  localparam logic [3:0] EXC_OPC = 4'h2;
  localparam logic [3:0] EXC_DIVZ = 4'h4;
  localparam logic [3:0] EXC_OVF = 4'h8;
  localparam logic [3:0] EXC_UNF = 4'ha;
  localparam logic [3:0] EXC_UNDEF = 4'hc;
  // register map and fields
  localparam logic [1:0] REG_MODE = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam int B_UV = 11;
  localparam int B_UNF = 10;
  localparam int B_OVF = 9;
  localparam int B_DBL = 7;
  localparam int B_LONG = 6;
  localparam int B_TRUNC = 5;
  localparam int B_N = 3;
  localparam int B_Z = 2;
  localparam int B_V = 1;
  localparam int B_C = 0;
  localparam int B_EXC_LO = 4;
  localparam logic [15:0] RD_NONE = 16'h0000;
endpackage : fau_pkg

// ---- test/fau_cpu_model.sv ----
// cpu core model: issues float instructions, reaches registers, takes condition codes
`timescale 1ns/1ps
`default_nettype none
module fau_cpu_model (
  // clock
  input  wire logic        clk,
  // register port
  output logic [1:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_we,
  output logic             reg_re,
  input  wire logic [15:0] reg_rdata,
  // instruction issue
  output logic             instr_valid,
  output logic [15:0]      instr_word,
  output logic [63:0]      float_source_operand,
  output logic [63:0]      float_dest_operand,
  // condition codes from the unit
  input  wire logic        cc_valid,
  input  wire logic        cpu_c,
  input  wire logic        cpu_v,
  input  wire logic        cpu_z,
  input  wire logic        cpu_n
);
  logic [3:0] cc_nzvc;
  // quiet bus at time zero
  initial begin
    {reg_addr, reg_wdata, reg_we, reg_re, instr_valid} = '0;
    {instr_word, float_source_operand, float_dest_operand} = '0;
    cc_nzvc = 4'h0;
  end
  // cpu takes all four codes on the copy strobe
  always @(posedge clk) if (cc_valid === 1'b1) cc_nzvc <= {cpu_n, cpu_z, cpu_v, cpu_c};
  // one instruction per call; back to back calls give back to back issue
  task automatic issue(input logic [15:0] w, input logic [63:0] s, input logic [63:0] d);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    float_source_operand <= s;
    float_dest_operand <= d;
  endtask : issue
  // released lines flip so stale values cannot look valid
  task automatic idle();
    @(posedge clk);
    instr_valid <= 1'b0;
    instr_word <= ~instr_word;
    float_source_operand <= ~float_source_operand;
    float_dest_operand <= ~float_dest_operand;
  endtask : idle
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    instr_valid <= 1'b0;
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    instr_valid <= 1'b0;
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : fau_cpu_model
`default_nettype wire

// ---- test/fau_float_unit_tb_top.sv ----
// self-checking bench for the floating add, absolute and copy-flags unit
`timescale 1ns/1ps
`default_nettype none
module fau_float_unit_tb_top;
  import fau_pkg::*;
  typedef struct {logic we; logic [63:0] w; logic t; logic [3:0] c; logic cc; logic [3:0] f;} fau_exp_t;
  logic clk, srst, reg_we, reg_re, instr_valid, done, result_we, trap, long_int_mode;
  logic cc_valid, cpu_c, cpu_v, cpu_z, cpu_n;
  logic [1:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, instr_word, rv;
  logic [63:0] float_source_operand, float_dest_operand, result_word, x, z;
  logic [3:0] exception_code_reg;
  int num_errors, samples_checked, seed, i;
  fau_exp_t exp_q[$];
  fau_exp_t e;
  localparam logic [63:0] ONE = {1'b0, 8'h81, 55'h0};
  localparam logic [63:0] BIG = {1'b0, 8'hff, 55'h0};
  localparam logic [63:0] NZ = {1'b1, 8'h00, 55'h0};
  // clock at 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  fau_float_unit u_fau_float_unit (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .instr_valid(instr_valid),
    .instr_word(instr_word), .float_source_operand(float_source_operand),
    .float_dest_operand(float_dest_operand), .done(done), .result_we(result_we), .result_word(result_word),
    .trap(trap), .exception_code_reg(exception_code_reg), .long_int_mode(long_int_mode),
    .cc_valid(cc_valid), .cpu_c(cpu_c), .cpu_v(cpu_v), .cpu_z(cpu_z), .cpu_n(cpu_n));
  fau_cpu_model u_fau_cpu_model (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .instr_valid(instr_valid), .instr_word(instr_word),
    .float_source_operand(float_source_operand), .float_dest_operand(float_dest_operand),
    .cc_valid(cc_valid), .cpu_c(cpu_c), .cpu_v(cpu_v), .cpu_z(cpu_z), .cpu_n(cpu_n));
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("ERROR t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // issue one instruction and note what should come back
  task automatic op(input logic [15:0] w, input logic [63:0] s, input logic [63:0] d, input logic we,
                    input logic [63:0] r, input logic t, input logic [3:0] c, input logic [3:0] f);
    u_fau_cpu_model.issue(w, s, d);
    exp_q.push_back('{we, r, t, c, w == 16'hf000, f});
  endtask : op
  task automatic note(input string n);
    u_fau_cpu_model.idle();
    repeat (3) @(posedge clk);
    $display("test %s finished", n);
  endtask : note
  // watcher: every done pops the oldest note
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(64'(done), 64'h0);
      end else begin
        e = exp_q.pop_front();
        chk(64'(result_we), 64'(e.we));
        if (e.we) chk(result_word, e.w);
        chk(64'(trap), 64'(e.t));
        if (e.t) chk(64'(exception_code_reg), 64'(e.c));
        chk(64'(cc_valid), 64'(e.cc));
        if (e.cc) chk(64'({cpu_n, cpu_z, cpu_v, cpu_c}), 64'(e.f));
      end
    end
  end
  // watchdog sized well past the whole sequence
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    test_done();
  end
  initial begin
    seed = 32'h5526;
    srst = 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    u_fau_cpu_model.rd(REG_MODE, rv);
    chk(64'(rv), 64'h0);
    u_fau_cpu_model.rd(REG_STAT, rv);
    chk(64'(rv), 64'h0);
    u_fau_cpu_model.wr(REG_MODE, 16'hffff);
    u_fau_cpu_model.rd(REG_MODE, rv);
    chk(64'(rv), 64'h0ee0);
    chk(64'(long_int_mode), 64'h1);
    u_fau_cpu_model.wr(2'h2, 16'hffff);
    u_fau_cpu_model.rd(2'h2, rv);
    chk(64'(rv), 64'h0);
    u_fau_cpu_model.rd(2'h3, rv);
    chk(64'(rv), 64'h0);
    note("registers");
    // double and single, round and truncate; back to back add, zero operand, copy flags
    u_fau_cpu_model.wr(REG_MODE, 16'h0080);
    x = {1'b0, 8'h93, 55'h2a5a5a5a5a5a5a};
    op(16'hf540, ONE, ONE, 1, {1'b0, 8'h82, 55'h0}, 0, 0, 0);
    op(16'hf580, {1'b0, 8'h00, 55'h123456789}, x, 1, x, 0, 0, 0);
    op(16'hf000, 0, 0, 0, 0, 0, 0, 4'h0);
    op(16'hf5c0, {1'b0, 8'h49, 55'h0}, ONE, 1, {1'b0, 8'h81, 55'h1}, 0, 0, 0);
    op(16'hf540, {1'b1, 8'h81, 55'h0}, ONE, 1, 64'h0, 0, 0, 0);
    op(16'hf000, 0, 0, 0, 0, 0, 0, 4'h4);
    u_fau_cpu_model.wr(REG_MODE, 16'h00a0);
    op(16'hf540, {1'b0, 8'h49, 55'h0}, ONE, 1, ONE, 0, 0, 0);
    u_fau_cpu_model.wr(REG_MODE, 16'h0000);
    op(16'hf540, {1'b0, 8'h69, 55'h0}, ONE, 1, {1'b0, 8'h81, 23'h1, 32'h0}, 0, 0, 0);
    u_fau_cpu_model.wr(REG_MODE, 16'h0020);
    op(16'hf540, {1'b0, 8'h69, 55'h0}, ONE, 1, ONE, 0, 0, 0);
    note("add and rounding");
    // minus zero handling with the trap enable
    u_fau_cpu_model.wr(REG_MODE, 16'h0880);
    op(16'hf508, {1'b1, 8'h00, 55'h5}, ONE, 0, 0, 1, EXC_UNDEF, 0);
    op(16'hf540, NZ, ONE, 1, ONE, 0, 0, 0);
    op(16'hf188, 0, {1'b1, 8'h00, 55'h7}, 1, 64'h0, 1, EXC_UNDEF, 0);
    op(16'hf180, 0, {1'b1, 8'h81, 55'h5}, 1, {1'b0, 8'h81, 55'h5}, 0, 0, 0);
    op(16'hf000, 0, 0, 0, 0, 0, 0, 4'h0);
    op(16'hf180, 0, {1'b0, 8'h00, 55'h9}, 1, 64'h0, 0, 0, 0);
    op(16'hf000, 0, 0, 0, 0, 0, 0, 4'h4);
    note("minus zero and absolute");
    // overflow and underflow, disabled then enabled
    u_fau_cpu_model.wr(REG_MODE, 16'h0080);
    op(16'hf540, BIG, BIG, 1, 64'h0, 0, 0, 0);
    op(16'hf000, 0, 0, 0, 0, 0, 0, 4'h6);
    u_fau_cpu_model.rd(REG_STAT, rv);
    chk(64'(rv), 64'h00c6);
    z = {1'b1, 8'h01, 55'h40000000000000};
    op(16'hf540, z, {1'b0, 8'h01, 55'h0}, 1, 64'h0, 0, 0, 0);
    u_fau_cpu_model.wr(REG_MODE, 16'h0280);
    op(16'hf540, BIG | NZ, BIG | NZ, 1, NZ, 1, EXC_OVF, 0);
    u_fau_cpu_model.wr(REG_MODE, 16'h0480);
    op(16'hf540, z, {1'b0, 8'h01, 55'h0}, 1, NZ, 1, EXC_UNF, 0);
    note("overflow and underflow");
    chk(64'(u_fau_cpu_model.cc_nzvc), 64'h6);
    // divide and unsupported codes
    op(16'hf940, 64'h0, ONE, 0, 0, 1, EXC_DIVZ, 0);
    op(16'hf940, ONE, ONE, 0, 0, 1, EXC_OPC, 0);
    op(16'hf240, ONE, ONE, 0, 0, 1, EXC_OPC, 0);
    note("divide and codes");
    // random zero sources leave the accumulator value unchanged
    u_fau_cpu_model.wr(REG_MODE, 16'h0080);
    for (i = 0; i < 24; i++) begin
      x = {$random(seed), $random(seed)};
      x[62:55] = x[62:55] | 8'h01;
      z = {$random(seed), $random(seed)};
      z[62:55] = 8'h00;
      rv = 16'(unsigned'($random(seed)));
      op({8'hf5, rv[7:0]}, z, x, 1, x, 0, 0, 0);
    end
    note("random");
    chk(64'(exp_q.size()), 64'h0);
    test_done();
  end
endmodule : fau_float_unit_tb_top
`default_nettype wire
